// file: verilog/pae_alarm_eval.sv
// Purpose: Alarm evaluator: per channel deviation or absolute alarms with delays.
// Assumes: All inputs synchronous to CLK_SYS_IN; raw analog word is 12 bits.
// Notes:   Evaluation runs once per sample tick; registers via Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module pae_alarm_eval
    import pae_pkg::*;
#(
    parameter int unsigned NUM_CH        = 3,
    parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
    parameter bit          HEATER_MON    = 1'b1
) (
    input  wire logic              CLK_SYS_IN,
    input  wire logic              RST_N_IN,
    input  wire logic [7:0]        AVS_ADDRESS_IN,
    input  wire logic              AVS_READ_IN,
    input  wire logic              AVS_WRITE_IN,
    input  wire logic [31:0]       AVS_WRITEDATA_IN,
    input  wire logic [3:0]        AVS_BYTEENABLE_IN,
    output var  logic [31:0]       AVS_READDATA_OUT,
    output var  logic              AVS_WAITREQUEST_OUT,
    input  wire logic [11:0]       ANALOG_RAW_IN,
    input  wire logic              LOOP_BREAK_IN,
    input  wire logic              HEATER_FAULT_IN,
    output var  logic [NUM_CH-1:0] AUX_OUT
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NUM_CH < 1 || NUM_CH > 3) begin : g_bad_ch
        $error("NUM_CH must be 1 to 3");
    end
    if (SAMPLE_CYCLES < 2) begin : g_bad_tick
        $error("SAMPLE_CYCLES must be at least 2");
    end
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    localparam int unsigned TW = $clog2(SAMPLE_CYCLES);
    localparam logic [TW-1:0] TICK_LAST = TW'(SAMPLE_CYCLES - 1);
    logic [TW-1:0]          tick_cnt;
    logic                   tick;
    logic [4:0]             in_type;
    logic [1:0]             dec_pos;
    logic signed [15:0]     target;
    logic signed [15:0]     scale_lo;
    logic signed [15:0]     scale_hi;
    logic [15:0]            hyst;
    logic [1:0]             asg [NUM_CH];
    logic signed [15:0]     meas;
    logic signed [15:0]     next_meas;
    logic [NUM_CH-1:0]      ch_hit;
    logic [NUM_CH-1:0]      cond;
    logic [NUM_CH-1:0]      state;
    logic [NUM_CH-1:0]      standby;
    pae_chcfg_t             cfg [NUM_CH];
    logic [31:0]            next_rdata;
    logic [31:0]            merged;
    logic                   wr_en;
    logic                   tgt_wr;
    logic                   hidden;
    // ------------------------------------------------------------
    // Sample tick
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
            tick     <= (tick_cnt == TICK_LAST);
        end
    end
    // ------------------------------------------------------------
    // Analog scaling
    // ------------------------------------------------------------
    // Live-zero ranges lose the bottom fifth of the converter span, so the
    // remainder is stretched by 5/4 to keep the full 12-bit resolution.
    always_comb begin
        logic [14:0]        stretched;
        logic [12:0]        eff;
        logic signed [31:0] span;
        logic signed [31:0] scaled;
        stretched = 15'(ANALOG_RAW_IN - LIVE_ZERO) * 15'h5;
        eff       = {1'b0, ANALOG_RAW_IN};
        if (in_type == IN_4_20MA || in_type == IN_1_5V) begin
            eff = (ANALOG_RAW_IN < LIVE_ZERO) ? 13'h0000 : 13'(stretched >> 2);
        end
        span   = 32'(scale_hi) - 32'(scale_lo);
        scaled = 32'(scale_lo) + ((span * $signed({19'h00000, eff})) >>> 12);
        if (scaled < 32'(MEAS_MIN)) begin
            next_meas = MEAS_MIN;
        end else if (scaled > 32'(MEAS_MAX)) begin
            next_meas = MEAS_MAX;
        end else begin
            next_meas = 16'(scaled);
        end
    end
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            meas <= 16'sh0000;
        end else if (tick) begin
            meas <= next_meas;
        end
    end
    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    assign wr_en  = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
    assign merged = pae_be_merge(next_rdata, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    assign tgt_wr = wr_en && AVS_ADDRESS_IN == REG_TARGET;
    assign hidden = HEATER_MON && asg[0] == ASG_HEATER;
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (AVS_ADDRESS_IN)
            REG_CTRL:   next_rdata = {22'h000000, dec_pos, 3'h0, in_type};
            REG_TARGET: next_rdata = 32'(target);
            REG_SCALE:  next_rdata = {scale_hi, scale_lo};
            REG_HYST:   next_rdata = {16'h0000, hyst};
            REG_STATUS: next_rdata = (32'(standby) << ST_SBY_LSB)
                                   | (32'(state) << ST_STATE_LSB) | 32'(cond);
            REG_MEAS:   next_rdata = 32'(meas);
            REG_ASSIGN: begin
                for (int k = 0; k < NUM_CH; k++) begin
                    next_rdata[2*k +: 2] = asg[k];
                end
            end
            default: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (ch_hit[c]) begin
                        unique case (AVS_ADDRESS_IN[3:2])
                            CH_TYPE:  next_rdata = (c == 0 && hidden) ? 32'h0000_0000
                                                 : 32'(cfg[c].kind);
                            CH_HIGH:  next_rdata = 32'(cfg[c].high);
                            CH_LOW:   next_rdata = 32'(cfg[c].low);
                            CH_DELAY: next_rdata = (32'(cfg[c].off_dly) << DLY_OFF_LSB)
                                                 | 32'(cfg[c].on_dly);
                        endcase
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            AVS_WAITREQUEST_OUT <= 1'b1;
            AVS_READDATA_OUT    <= 32'h0000_0000;
        end else begin
            AVS_WAITREQUEST_OUT <= !((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT);
            AVS_READDATA_OUT    <= next_rdata;
        end
    end
    sequence s_req_seen;
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
    endsequence
    sequence s_one_wait_low;
        !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
    endsequence
    a_bus_answer_once: assert property (s_req_seen |=> s_one_wait_low)
        else $error("bus answer not exactly one cycle");
    // Global configuration; input codes outside IN_4_20MA to IN_0_10V are refused.
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            in_type  <= IN_4_20MA;
            dec_pos  <= 2'h0;
            target   <= 16'sh0000;
            scale_lo <= RST_SCALE_LO;
            scale_hi <= RST_SCALE_HI;
            hyst     <= RST_HYST;
        end else if (wr_en) begin
            unique case (AVS_ADDRESS_IN)
                REG_CTRL: begin
                    if (merged[4:0] >= IN_4_20MA && merged[4:0] <= IN_0_10V) begin
                        in_type <= merged[4:0];
                    end
                    dec_pos <= merged[CTRL_DP_LSB +: 2];
                end
                REG_TARGET: target <= merged[15:0];
                REG_SCALE: begin
                    scale_lo <= merged[15:0];
                    scale_hi <= merged[31:16];
                end
                REG_HYST: hyst <= merged[15:0];
                default: ;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Auxiliary output routing
    // ------------------------------------------------------------
    for (genvar k = 0; k < NUM_CH; k++) begin : g_aux
        always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                asg[k] <= (k == 0 && HEATER_MON) ? ASG_HEATER : 2'(k);
            end else if (wr_en && AVS_ADDRESS_IN == REG_ASSIGN) begin
                asg[k] <= merged[2*k +: 2];
            end
        end

        always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                AUX_OUT[k] <= 1'b0;
            end else if (asg[k] == ASG_HEATER) begin
                AUX_OUT[k] <= HEATER_FAULT_IN;
            end else if (32'(asg[k]) < NUM_CH) begin
                AUX_OUT[k] <= state[asg[k]];
            end else begin
                AUX_OUT[k] <= 1'b0;
            end
        end
        a_aux_follow_alarm: assert property (
            (32'(asg[k]) < NUM_CH) && $stable(asg[k])
            |=> AUX_OUT[k] == $past(state[asg[k]]))
            else $error("aux output does not follow its alarm");
    end
    // ------------------------------------------------------------
    // Alarm channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic               sb_type;
        logic               overlap;
        logic               eff;
        logic [14:0]        cnt;
        logic [14:0]        lim;
        logic               type_ok;
        assign ch_hit[c] = AVS_ADDRESS_IN[7:4] == CH_PAGE0 + 4'(c);
        assign sb_type   = cfg[c].kind inside {TY_BAND_SB, TY_UPPER_SB, TY_LOWER_SB,
                                               TY_ABS_HI_SB, TY_ABS_LO_SB};
        // Code 12 is refused off the first channel; a hidden type is read-only.
        assign type_ok   = merged[4:0] <= TY_LAST
                        && !(merged[4:0] == TY_LOOP && c != 0)
                        && !(c == 0 && hidden);
        always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                cfg[c] <= '{kind: TY_UPPER, high: 16'sh0000, low: 16'sh0000,
                            on_dly: 10'h000, off_dly: 10'h000};
            end else if (wr_en && ch_hit[c]) begin
                unique case (AVS_ADDRESS_IN[3:2])
                    CH_TYPE: begin
                        if (type_ok) begin
                            cfg[c].kind <= merged[4:0];
                        end
                    end
                    CH_HIGH: cfg[c].high <= merged[15:0];
                    CH_LOW:  cfg[c].low  <= merged[15:0];
                    CH_DELAY: begin
                        if (merged[9:0] <= DLY_MAX_S) begin
                            cfg[c].on_dly <= merged[9:0];
                        end
                        if (merged[DLY_OFF_LSB +: 10] <= DLY_MAX_S) begin
                            cfg[c].off_dly <= merged[DLY_OFF_LSB +: 10];
                        end
                    end
                endcase
            end
        end
        // Single-threshold types use the high register as their threshold.
        always_comb begin
            logic signed [17:0] pv;
            logic signed [17:0] up;
            logic signed [17:0] dn;
            pv      = 18'(meas);
            up      = 18'(target) + 18'(cfg[c].high);
            dn      = 18'(target) - 18'(cfg[c].low);
            overlap = (18'(cfg[c].high) + 18'(cfg[c].low)) < 18'({hyst, 1'b0});
            unique case (cfg[c].kind)
                TY_BAND_OUT:  cond[c] = pv > up || pv < dn;
                TY_BAND_SB:   cond[c] = !overlap && (pv > up || pv < dn);
                TY_BAND_IN:   cond[c] = pv >= dn && pv <= up;
                TY_UPPER,
                TY_UPPER_SB:  cond[c] = pv >= up;
                TY_LOWER,
                TY_LOWER_SB:  cond[c] = pv <= 18'(target) - 18'(cfg[c].high);
                TY_ABS_HI,
                TY_ABS_HI_SB: cond[c] = meas > cfg[c].high;
                TY_ABS_LO,
                TY_ABS_LO_SB: cond[c] = meas < cfg[c].high;
                TY_LOOP:      cond[c] = (c == 0) && LOOP_BREAK_IN;
                default:      cond[c] = 1'b0;
            endcase
        end
        // Standby re-arms on power-up and on every target change and is
        // released by the first sample that finds the condition clear.
        always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                standby[c] <= 1'b1;
            end else if (tgt_wr) begin
                standby[c] <= 1'b1;
            end else if (tick && !cond[c]) begin
                standby[c] <= 1'b0;
            end
        end
        assign eff = cond[c] && !(sb_type && standby[c]);
        assign lim = (state[c] ? 15'(cfg[c].off_dly) : 15'(cfg[c].on_dly))
                   * 15'(SAMPLES_PER_SEC);
        always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                state[c] <= 1'b0;
                cnt      <= 15'h0000;
            end else if (cfg[c].kind == TY_OFF) begin
                state[c] <= 1'b0;
                cnt      <= 15'h0000;
            end else if (tick) begin
                if (eff == state[c]) begin
                    cnt <= 15'h0000;
                end else if (cnt >= lim) begin
                    state[c] <= eff;
                    cnt      <= 15'h0000;
                end else begin
                    cnt <= cnt + 15'h0001;
                end
            end
        end
        a_type_reset_val: assert property ($rose(RST_N_IN) |-> cfg[c].kind == TY_UPPER)
            else $error("alarm type not reset to upper deviation");
        a_delay_in_range: assert property (
            cfg[c].on_dly <= DLY_MAX_S && cfg[c].off_dly <= DLY_MAX_S)
            else $error("delay above 999 seconds");
        a_off_type_idle: assert property (cfg[c].kind == TY_OFF |=> !state[c])
            else $error("disabled channel output active");
        a_switch_after_delay: assert property (
            $changed(state[c]) |-> $past(tick) && $past(cnt) == $past(lim)
                                   && $past(cfg[c].kind) != TY_OFF || !state[c])
            else $error("alarm switched before its delay");
        a_standby_holds_off: assert property (
            sb_type && standby[c] && !state[c] |=> !state[c] || $past(tgt_wr))
            else $error("standby did not suppress the alarm");
        a_upper_dev_fires: assert property (
            cfg[c].kind == TY_UPPER && tick && !state[c] && cfg[c].on_dly == 10'h000
            && 18'(meas) >= 18'(target) + 18'(cfg[c].high) |=> state[c])
            else $error("upper deviation alarm did not fire");
        a_overlap_forced_off: assert property (
            cfg[c].kind == TY_BAND_SB && overlap && tick && state[c]
            && cfg[c].off_dly == 10'h000 |=> !state[c])
            else $error("overlapping band alarm stayed on");
        if (c > 0) begin : g_loop_chk
            a_loop_rejected: assert property (
                wr_en && ch_hit[c] && AVS_ADDRESS_IN[3:2] == CH_TYPE
                && merged[4:0] == TY_LOOP |=> cfg[c].kind == $past(cfg[c].kind))
                else $error("loop break type accepted off first channel");
        end
    end
endmodule // pae_alarm_eval
`default_nettype wire

// file: include/pae_pkg.sv
// Purpose: Shared constants and types of the process alarm evaluator.
// Assumes: 10 MHz system clock, 16-bit signed process values.
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave.
package pae_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned SAMPLE_MS       = 50;
    localparam int unsigned SAMPLE_CYC      = CLK_HZ / 1000 * SAMPLE_MS;
    localparam int unsigned SAMPLES_PER_SEC = 1000 / SAMPLE_MS;
    localparam logic [9:0]  DLY_MAX_S       = 10'h3E7;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TARGET = 8'h04;
    localparam logic [7:0] REG_SCALE  = 8'h08;
    localparam logic [7:0] REG_HYST   = 8'h0C;
    localparam logic [7:0] REG_ASSIGN = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_MEAS   = 8'h18;
    localparam logic [3:0] CH_PAGE0   = 4'h2;
    localparam logic [1:0] CH_TYPE    = 2'h0;
    localparam logic [1:0] CH_HIGH    = 2'h1;
    localparam logic [1:0] CH_LOW     = 2'h2;
    localparam logic [1:0] CH_DELAY   = 2'h3;
    localparam int unsigned CTRL_DP_LSB = 8;
    localparam int unsigned DLY_OFF_LSB = 16;
    localparam int unsigned ST_STATE_LSB = 8;
    localparam int unsigned ST_SBY_LSB   = 16;
    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] TY_OFF       = 5'h00;
    localparam logic [4:0] TY_BAND_OUT  = 5'h01;
    localparam logic [4:0] TY_UPPER     = 5'h02;
    localparam logic [4:0] TY_LOWER     = 5'h03;
    localparam logic [4:0] TY_BAND_IN   = 5'h04;
    localparam logic [4:0] TY_BAND_SB   = 5'h05;
    localparam logic [4:0] TY_UPPER_SB  = 5'h06;
    localparam logic [4:0] TY_LOWER_SB  = 5'h07;
    localparam logic [4:0] TY_ABS_HI    = 5'h08;
    localparam logic [4:0] TY_ABS_LO    = 5'h09;
    localparam logic [4:0] TY_ABS_HI_SB = 5'h0A;
    localparam logic [4:0] TY_ABS_LO_SB = 5'h0B;
    localparam logic [4:0] TY_LOOP      = 5'h0C;
    localparam logic [4:0] TY_LAST      = 5'h13;
    localparam logic [4:0] IN_4_20MA    = 5'h19;
    localparam logic [4:0] IN_1_5V      = 5'h1B;
    localparam logic [4:0] IN_0_10V     = 5'h1D;
    localparam logic [1:0] ASG_HEATER   = 2'h3;
    localparam logic [11:0] LIVE_ZERO   = 12'h333;
    localparam logic signed [15:0] MEAS_MIN = 16'shF831;
    localparam logic signed [15:0] MEAS_MAX = 16'sh270F;
    localparam logic signed [15:0] RST_SCALE_LO = 16'sh0000;
    localparam logic signed [15:0] RST_SCALE_HI = 16'sh03E8;
    localparam logic [15:0] RST_HYST    = 16'h0001;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0]         kind;
        logic signed [15:0] high;
        logic signed [15:0] low;
        logic [9:0]         on_dly;
        logic [9:0]         off_dly;
    } pae_chcfg_t;

    function automatic logic [31:0] pae_be_merge(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction
endpackage

// file: dv/test_process_alarm_evaluator.sv
// Purpose: Self-checking bench for the process alarm evaluator.
// Assumes: Sample tick every 4 clocks, 3 channels, heater monitor present.
// Notes:   Registers are reached over Avalon-MM; one task per scenario.
`timescale 1ns/1ps
`default_nettype none
module test_process_alarm_evaluator;
    import pae_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and checking
    // ------------------------------------------------------------
    localparam int SC = 4;
    // Three ticks: latch the value, evaluate it, then two clocks to the pin.
    localparam int SETTLE = 3 * SC + 2;
    logic        clk_sys, rst_n, rd, wr, wait_req, lbrk, hfault;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [11:0] raw;
    logic [2:0]  aux;
    int          n_mismatch = 0;
    int          check_count = 0;

    pae_alarm_eval #(.NUM_CH(3), .SAMPLE_CYCLES(SC), .HEATER_MON(1'b1)) uut (
        .CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
        .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(wait_req), .ANALOG_RAW_IN(raw),
        .LOOP_BREAK_IN(lbrk), .HEATER_FAULT_IN(hfault), .AUX_OUT(aux));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic conclude;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The request is held until waitrequest is seen low, then released.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (wait_req !== 1'b0) begin
            n_mismatch++;
            conclude();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic t_reset;
        // The first channel's type reads as zero while the heater alarm owns it.
        bus(0, 8'h20, 32'h0); chk(q, 32'h0);
        bus(0, 8'h30, 32'h0); chk(q, 32'h2);
        bus(0, REG_ASSIGN, 32'h0); chk(q, 32'h27);
        bus(0, 8'hFC, 32'h0); chk(q, 32'h0);
        bus(1, 8'h30, 32'hC); bus(0, 8'h30, 32'h0); chk(q, 32'h2);
        bus(1, 8'h30, 32'h14); bus(0, 8'h30, 32'h0); chk(q, 32'h2);
        chk({31'h0, aux[2]}, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_heater;
        hfault <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({31'h0, aux[0]}, 32'h1);
        bus(1, 8'h20, 32'h1); bus(0, 8'h20, 32'h0); chk(q, 32'h0);
        bus(1, REG_ASSIGN, 32'h24); bus(0, 8'h20, 32'h0); chk(q, 32'h2);
        bus(1, 8'h20, 32'hC); bus(0, 8'h20, 32'h0); chk(q, 32'hC);
        repeat (SETTLE) @(posedge clk_sys);
        chk({31'h0, aux[0]}, 32'h0);
        lbrk <= 1'b1;
        repeat (SETTLE) @(posedge clk_sys);
        chk({31'h0, aux[0]}, 32'h1);
        bus(1, 8'h20, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, aux[0]}, 32'h0);
        $display("test heater done");
    endtask

    task automatic t_types;
        logic [4:0] ty [6] = '{5'h1, 5'h2, 5'h3, 5'h4, 5'h8, 5'h9};
        // Bit i gives the expected level for ty[i]; row 0 high value, row 1 zero.
        logic [5:0] ex [2] = '{6'h13, 6'h28};
        bus(1, 8'h34, 32'hA);
        bus(1, 8'h38, 32'hA);
        for (int v = 0; v < 2; v++) begin
            raw <= (v == 0) ? 12'hFFF : 12'h333;
            repeat (SETTLE) @(posedge clk_sys);
            bus(0, REG_MEAS, 32'h0); chk(q, (v == 0) ? 32'h3E7 : 32'h0);
            for (int i = 0; i < 6; i++) begin
                bus(1, 8'h30, {27'h0, ty[i]});
                repeat (SETTLE) @(posedge clk_sys);
                chk({31'h0, aux[1]}, {31'h0, ex[v][i]});
            end
        end
        bus(1, REG_CTRL, 32'h1A);
        repeat (SETTLE) @(posedge clk_sys);
        bus(0, REG_MEAS, 32'h0);
        chk(q, 32'hC7);
        bus(1, REG_CTRL, 32'h1E);
        bus(0, REG_CTRL, 32'h0);
        chk(q, 32'h1A);
        bus(1, REG_CTRL, 32'h19);
        $display("test types done");
    endtask

    // A target write re-arms standby, so the alarm must first see a clear reading.
    task automatic t_standby;
        logic [4:0] ty [5] = '{5'h5, 5'h6, 5'h7, 5'hA, 5'hB};
        // Bit i set: ty[i] is active at the low reading, against a target of 100.
        logic [4:0] lo_on = 5'h14;
        for (int i = 0; i < 5; i++) begin
            bus(1, 8'h30, {27'h0, ty[i]});
            raw <= lo_on[i] ? 12'h333 : 12'hFFF;
            repeat (SETTLE) @(posedge clk_sys);
            bus(1, REG_TARGET, lo_on[i] ? 32'h64 : 32'h0);
            repeat (SETTLE) @(posedge clk_sys);
            chk({31'h0, aux[1]}, 32'h0);
            raw <= lo_on[i] ? 12'hFFF : 12'h333;
            repeat (SETTLE) @(posedge clk_sys);
            raw <= lo_on[i] ? 12'h333 : 12'hFFF;
            repeat (SETTLE) @(posedge clk_sys);
            chk({31'h0, aux[1]}, 32'h1);
            if (i == 0) begin
                bus(1, REG_HYST, 32'h20);
                repeat (SETTLE) @(posedge clk_sys);
                chk({31'h0, aux[1]}, 32'h0);
                bus(1, REG_HYST, 32'h1);
            end
        end
        $display("test standby done");
    endtask

    task automatic t_delay;
        bus(1, 8'h30, 32'h2);
        repeat (SETTLE) @(posedge clk_sys);
        bus(1, 8'h3C, 32'h1);
        raw <= 12'hFFF;
        // One second is 20 ticks of 4 clocks, so the pin cannot rise within 80 clocks.
        repeat (80) @(posedge clk_sys);
        chk({31'h0, aux[1]}, 32'h0);
        repeat (30) @(posedge clk_sys);
        chk({31'h0, aux[1]}, 32'h1);
        bus(1, 8'h3C, 32'h3E8); bus(0, 8'h3C, 32'h0); chk(q, 32'h1);
        $display("test delay done");
    endtask

    initial begin
        {rst_n, rd, wr, lbrk, hfault} = '0;
        addr = 8'h00;
        wdata = 32'h0;
        raw = 12'h333;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_heater();
        t_types();
        t_standby();
        t_delay();
        conclude();
    end

    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end
endmodule // test_process_alarm_evaluator
`default_nettype wire
